// ==== core/mts_sensor.v ====
// Purpose: thermal sensor slave on the two-wire management bus
// Assumes: bus pins and straps sampled in clk domain; temperature from converter port
// Notes: open-drain pins split into in/out/enable; enable high while pulling low
`timescale 1ns/1ps
`include "mts_map.vh"
module mts_sensor
(
   // System
   input wire clk,
   input wire sys_rst,
   // Two-wire bus
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Address straps
   input wire addr_strap_bit0,
   input wire addr_strap_bit1,
   input wire addr_strap_bit2,
   // Converter
   input wire [12:0] temp_sample,
   input wire temp_valid,
   // Alert pin
   output reg alert_out,
   output reg alert_oe
);

// ----------------------------------------
// Input conditioning
// ----------------------------------------
wire scl_s;
wire sda_s;
wire [2:0] strap_s;

mts_sync3 u_scl (.clk(clk), .sys_rst(sys_rst), .async_in(scl_in), .sync_out(scl_s));
mts_sync3 u_sda (.clk(clk), .sys_rst(sys_rst), .async_in(sda_in), .sync_out(sda_s));
mts_sync3 u_a0 (.clk(clk), .sys_rst(sys_rst), .async_in(addr_strap_bit0), .sync_out(strap_s[0]));
mts_sync3 u_a1 (.clk(clk), .sys_rst(sys_rst), .async_in(addr_strap_bit1), .sync_out(strap_s[1]));
mts_sync3 u_a2 (.clk(clk), .sys_rst(sys_rst), .async_in(addr_strap_bit2), .sync_out(strap_s[2]));

reg scl_d_reg;
reg sda_d_reg;
wire scl_rise = scl_s & ~scl_d_reg;
wire scl_fall = ~scl_s & scl_d_reg;
wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

// ----------------------------------------
// Registers
// ----------------------------------------
reg [15:0] setup_reg;
reg [15:0] high_reg;
reg [15:0] low_reg;
reg [15:0] crit_reg;
reg [15:0] reading_reg;
reg [3:0] sel_reg;
reg sel_bad_reg;
reg event_reg;
reg above_reg;
reg below_reg;
reg crit_hit_reg;

// ----------------------------------------
// Bus engine
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_AACK = 3'h2;
localparam ST_WBYTE = 3'h3;
localparam ST_WACK = 3'h4;
localparam ST_RBYTE = 3'h5;
localparam ST_RACK = 3'h6;

reg [2:0] state_reg;
reg [3:0] bit_reg;
reg [7:0] shift_reg;
reg rd_reg;
reg [1:0] wcount_reg;
reg [7:0] wmsb_reg;
reg rsecond_reg;
reg [15:0] rdata_reg;

wire addr_match = (shift_reg[7:4] == `MTS_ADDR_PREFIX) && (shift_reg[3:1] == strap_s);

// Selected register read value
reg [15:0] sel_data;
always @*
begin
   sel_data = 16'h0000;
   if (!sel_bad_reg)
   begin
      case (sel_reg)
         `MTS_SEL_FEATURE: sel_data = `MTS_FEATURE_RST;
         `MTS_SEL_SETUP: sel_data = {setup_reg[15:5], event_reg, setup_reg[3:0]};
         `MTS_SEL_HIGH: sel_data = high_reg;
         `MTS_SEL_LOW: sel_data = low_reg;
         `MTS_SEL_CRIT: sel_data = crit_reg;
         `MTS_SEL_READING: sel_data = {crit_hit_reg, above_reg, below_reg, reading_reg[12:0]};
         default: sel_data = 16'h0000;
      endcase
   end
end

wire locked = setup_reg[`MTS_CFG_WINLOCK] | setup_reg[`MTS_CFG_CRITLOCK];
wire [15:0] wword = {wmsb_reg, shift_reg};
wire word_done = (state_reg == ST_WBYTE) && scl_fall && (bit_reg == 4'h8) && (wcount_reg == 2'h2);
wire clear_req = word_done && !sel_bad_reg && (sel_reg == `MTS_SEL_SETUP) && wword[`MTS_CFG_CLEAR];

always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      rd_reg <= 1'b0;
      wcount_reg <= 2'h0;
      wmsb_reg <= 8'h00;
      rsecond_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      sel_reg <= 4'h0;
      sel_bad_reg <= 1'b0;
      setup_reg <= `MTS_SETUP_RST;
      high_reg <= `MTS_LIMIT_RST;
      low_reg <= `MTS_LIMIT_RST;
      crit_reg <= `MTS_LIMIT_RST;
   end
   else
   begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (start_cond)
      begin
         state_reg <= ST_ADDR;
         bit_reg <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
         state_reg <= ST_IDLE;
         sda_oe <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_WBYTE:
            begin
               if (scl_rise)
               begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_reg <= bit_reg + 4'h1;
               end
               else if (scl_fall && bit_reg == 4'h8)
               begin
                  bit_reg <= 4'h0;
                  if (state_reg == ST_ADDR)
                  begin
                     if (addr_match)
                     begin
                        rd_reg <= shift_reg[0];
                        wcount_reg <= 2'h0;
                        rsecond_reg <= 1'b0;
                        rdata_reg <= sel_data;
                        sda_oe <= 1'b1;
                        state_reg <= ST_AACK;
                     end
                     else
                        state_reg <= ST_IDLE;
                  end
                  else
                  begin
                     sda_oe <= 1'b1;
                     state_reg <= ST_WACK;
                     if (wcount_reg == 2'h0)
                     begin
                        sel_reg <= shift_reg[3:0];
                        sel_bad_reg <= (shift_reg[7:4] != 4'h0) || (shift_reg[3:0] > `MTS_SEL_READING);
                        wcount_reg <= 2'h1;
                     end
                     else if (wcount_reg == 2'h1)
                     begin
                        wmsb_reg <= shift_reg;
                        wcount_reg <= 2'h2;
                     end
                     else
                     begin
                        wcount_reg <= 2'h1;
                        if (!sel_bad_reg)
                        begin
                           case (sel_reg)
                              `MTS_SEL_SETUP:
                              begin
                                 setup_reg <= wword & `MTS_CFG_WMASK;
                                 if (locked)
                                 begin
                                    setup_reg[`MTS_CFG_MODE] <= setup_reg[`MTS_CFG_MODE];
                                    setup_reg[`MTS_CFG_POL] <= setup_reg[`MTS_CFG_POL];
                                 end
                              end
                              `MTS_SEL_HIGH:
                                 if (!setup_reg[`MTS_CFG_WINLOCK])
                                    high_reg <= wword & `MTS_LIMIT_MASK;
                              `MTS_SEL_LOW:
                                 if (!setup_reg[`MTS_CFG_WINLOCK])
                                    low_reg <= wword & `MTS_LIMIT_MASK;
                              `MTS_SEL_CRIT:
                                 if (!setup_reg[`MTS_CFG_CRITLOCK])
                                    crit_reg <= wword & `MTS_LIMIT_MASK;
                              default:
                              begin
                              end
                           endcase
                        end
                     end
                  end
               end
            end
            ST_AACK:
            begin
               sda_out <= 1'b0;
               if (scl_fall)
               begin
                  if (rd_reg)
                  begin
                     sda_oe <= ~rdata_reg[15];
                     shift_reg <= rdata_reg[15:8];
                     bit_reg <= 4'h1;
                     state_reg <= ST_RBYTE;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state_reg <= ST_WBYTE;
                  end
               end
            end
            ST_WACK:
            begin
               if (scl_fall)
               begin
                  sda_oe <= 1'b0;
                  state_reg <= ST_WBYTE;
               end
            end
            ST_RBYTE:
            begin
               if (scl_fall)
               begin
                  if (bit_reg == 4'h8)
                  begin
                     sda_oe <= 1'b0;
                     state_reg <= ST_RACK;
                  end
                  else
                  begin
                     sda_oe <= ~shift_reg[3'h7 - bit_reg[2:0]];
                     bit_reg <= bit_reg + 4'h1;
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
                  rd_reg <= ~sda_s;
               else if (scl_fall)
               begin
                  if (rd_reg)
                  begin
                     rsecond_reg <= ~rsecond_reg;
                     shift_reg <= rsecond_reg ? sel_data[15:8] : rdata_reg[7:0];
                     if (rsecond_reg)
                        rdata_reg <= sel_data;
                     sda_oe <= rsecond_reg ? ~sel_data[15] : ~rdata_reg[7];
                     bit_reg <= 4'h1;
                     state_reg <= ST_RBYTE;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
end

// ----------------------------------------
// Monitoring and alert
// ----------------------------------------
// Hysteresis widened to temperature LSBs; limits share the 0.0625 C scale
reg [15:0] hyst;
always @*
begin
   case (setup_reg[`MTS_CFG_HYST_HI:`MTS_CFG_HYST_LO])
      2'h1: hyst = `MTS_HYST_1;
      2'h2: hyst = `MTS_HYST_2;
      2'h3: hyst = `MTS_HYST_3;
      default: hyst = 16'h0000;
   endcase
end

// Sign-extend 13-bit fields to 16 bits for signed compare
wire signed [15:0] t_s = {{3{reading_reg[12]}}, reading_reg[12:0]};
wire signed [15:0] hi_s = {{3{high_reg[12]}}, high_reg[12:0]};
wire signed [15:0] lo_s = {{3{low_reg[12]}}, low_reg[12:0]};
wire signed [15:0] cr_s = {{3{crit_reg[12]}}, crit_reg[12:0]};
wire signed [15:0] hy_s = hyst;

wire above_next = above_reg ? (t_s >= hi_s - hy_s) : (t_s > hi_s);
wire below_next = below_reg ? (t_s <= lo_s) : (t_s < lo_s - hy_s);
wire crit_next = crit_hit_reg ? (t_s >= cr_s - hy_s) : (t_s > cr_s);
wire int_mode = setup_reg[`MTS_CFG_MODE];
wire crit_only = setup_reg[`MTS_CFG_CRITONLY];
wire win_cond = ~crit_only & (above_next | below_next);
wire new_trip = (win_cond & ~(~crit_only & (above_reg | below_reg))) | (crit_next & ~crit_hit_reg);
wire alert_drive = setup_reg[`MTS_CFG_OUTEN] & (event_reg ^ setup_reg[`MTS_CFG_POL]);

always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      reading_reg <= 16'h0000;
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      crit_hit_reg <= 1'b0;
      event_reg <= 1'b0;
      alert_out <= 1'b0;
      alert_oe <= 1'b0;
   end
   else
   begin
      if (temp_valid && !setup_reg[`MTS_CFG_SHDN])
         reading_reg <= {3'h0, temp_sample};
      above_reg <= above_next;
      below_reg <= below_next;
      crit_hit_reg <= crit_next;
      if (crit_next)
         event_reg <= 1'b1;
      else if (!int_mode)
         event_reg <= win_cond;
      else if (new_trip)
         event_reg <= 1'b1;
      else if (clear_req)
         event_reg <= 1'b0;
      alert_out <= 1'b0;
      alert_oe <= alert_drive;
   end
end

endmodule

// ==== core/mts_map.vh ====
// Purpose: constants for the module thermal sensor slave
// Assumes: 100 MHz system clock, two-wire bus pins sampled in that domain
// Notes: included by the sensor core and the bench top level
//
// Contract
// - Temperature sampled continuously; latest reading readable anytime without request.
// - Alert is open-drain, only pulls low or releases, sensor-driven.
// - Alert has interrupt, comparator and critical-only behaviours via configuration.
// - Alert asserts when temperature above upper or below lower bound.
// - Thresholds use hysteresis held in configuration register 0x01.
// - Interrupt mode alert holds until software clears it by a write.
// - Interrupt mode raises on critical crossing and either window bound.
// - Comparator mode ignores clear; releases only when back inside thresholds.
// - Critical-only mode asserts solely above critical limit, ignores window.
// - Critical alert behaves as comparator; software clear cannot remove it.
// - Bus address upper bits fixed 0011, then three strap bits, then R/W.
// - Three straps select eight addresses, bytes 30h through 3Eh.
// - Registers at pointer 0x00 through 0x05 in documented order.
// - Reset: capability 0x0001, others 0x0000; pointer and temperature undefined.
// - Pointer write selects the 16-bit register for later transfers.
// - Pointer is write-only; reads return the selected data register.
// - Pointer is eight bits; upper four zero, lower four select.
// - Config bit 0 selects interrupt/comparator; locked while either lock set.
// - Writing 1 to config bit 5 clears pending interrupt alert.
// - Config bit 3 gates the alert output; 0 keeps it released.
// - Thresholds and temperature are two's complement.
`ifndef MTS_MAP_VH
`define MTS_MAP_VH

// ----------------------------------------
// Bus address
// ----------------------------------------
`define MTS_ADDR_PREFIX 4'h3
// ----------------------------------------
// Register selectors
// ----------------------------------------
`define MTS_SEL_FEATURE 4'h0
`define MTS_SEL_SETUP 4'h1
`define MTS_SEL_HIGH 4'h2
`define MTS_SEL_LOW 4'h3
`define MTS_SEL_CRIT 4'h4
`define MTS_SEL_READING 4'h5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MTS_FEATURE_RST 16'h0001
`define MTS_SETUP_RST 16'h0000
`define MTS_LIMIT_RST 16'h0000
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define MTS_CFG_MODE 0
`define MTS_CFG_POL 1
`define MTS_CFG_CRITONLY 2
`define MTS_CFG_OUTEN 3
`define MTS_CFG_STATUS 4
`define MTS_CFG_CLEAR 5
`define MTS_CFG_WINLOCK 6
`define MTS_CFG_CRITLOCK 7
`define MTS_CFG_SHDN 8
`define MTS_CFG_HYST_LO 9
`define MTS_CFG_HYST_HI 10
// Writable bits of configuration (status and RFU read back as hardware sets)
`define MTS_CFG_WMASK 16'h07CF
// Limit registers: bits 12:2 only
`define MTS_LIMIT_MASK 16'h1FFC
// Hysteresis in temperature LSBs (0.0625 C): 1.5, 3, 6 C
`define MTS_HYST_1 16'h0018
`define MTS_HYST_2 16'h0030
`define MTS_HYST_3 16'h0060

`endif

// ==== core/mts_sync3.v ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module mts_sync3
(
   // System
   input wire clk,
   input wire sys_rst,
   // Data
   input wire async_in,
   output reg sync_out
);

reg s1_reg;
reg s2_reg;
reg s3_reg;

always @(posedge clk or posedge sys_rst)
begin
   if (sys_rst)
   begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      sync_out <= 1'b1;
   end
   else
   begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
         sync_out <= s3_reg;
   end
end

endmodule

// ==== bench/mts_sensor_sva.sv ====
// Purpose: port checks for the thermal sensor slave
// Assumes: bound to mts_sensor, bus pins synchronised in a few clocks
// Notes: bus drive is judged against the raw clock pin level
`timescale 1ns/1ps
module mts_sensor_sva
(
   // System
   input wire clk,
   input wire sys_rst,
   // Inputs watched
   input wire scl_in,
   input wire temp_valid,
   // Pins
   input wire sda_out,
   input wire sda_oe,
   input wire alert_out,
   input wire alert_oe
);
   reg [3:0] since_tv_reg;
   // Saturating age of the last sample, so alert moves can be traced to a cause
   always @(posedge clk or posedge sys_rst)
      if (sys_rst)
         since_tv_reg <= 4'hF;
      else if (temp_valid)
         since_tv_reg <= 4'h0;
      else if (since_tv_reg != 4'hF)
         since_tv_reg <= since_tv_reg + 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_quiet;
      (!sda_oe && !alert_oe) [*4];
   endsequence
   sequence s_held;
      sda_oe [*3];
   endsequence
   chk_alert_open_drain: assert property (!alert_out) else $error("alert driven high");
   chk_sda_open_drain: assert property (!sda_out) else $error("sda driven high");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> s_quiet) else $error("pins busy after reset");
   chk_ack_clock_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 2)) else $error("drive began high");
   chk_sda_moves_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved in high");
   chk_drive_held: assert property ($rose(sda_oe) |-> s_held) else $error("sda drive glitch");
   chk_drive_bounded: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe) else $error("sda stuck");
   chk_alert_has_cause: assert property ($changed(alert_oe) |-> (!scl_in || since_tv_reg < 4'h8))
      else $error("alert moved without cause");
endmodule
bind mts_sensor mts_sensor_sva chk_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .temp_valid(temp_valid),
   .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe));

// ==== bench/mts_host_model.sv ====
// Purpose: host bus master facing the sensor
// Assumes: quarter bit period of Q clocks, pull-up on SDA
// Notes: SDA released to the pull-up whenever not pulled low
`timescale 1ns/1ps
module mts_host_model
#(
   parameter Q = 8
)
(
   // System
   input wire clk,
   // Bus
   input wire sda_line,
   output reg scl_line,
   output reg sda_low
);
   initial
   begin
      scl_line = 1'h1;
      sda_low = 1'h0;
   end
   task tick;
      repeat (Q) @(posedge clk);
      #1;
   endtask
   task xfer_bit(input logic b, output logic r);
      sda_low = !b;
      tick;
      scl_line = 1'h1;
      tick;
      r = sda_line;
      tick;
      scl_line = 1'h0;
      tick;
   endtask
   task bus_start;
      sda_low = 1'h0;
      tick;
      scl_line = 1'h1;
      tick;
      sda_low = 1'h1;
      tick;
      scl_line = 1'h0;
      tick;
   endtask
   task bus_stop;
      sda_low = 1'h1;
      tick;
      scl_line = 1'h1;
      tick;
      sda_low = 1'h0;
      tick;
   endtask
   task put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(b[i], r);
      xfer_bit(1'h1, r);
      ack = !r;
   endtask
   task get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(1'h1, b[i]);
      xfer_bit(last, r);
   endtask
   task wr_reg(input logic [2:0] sel, input logic [7:0] ptr, input logic [15:0] d, output logic ok);
      logic [3:0] a;
      bus_start;
      put_byte({4'h3, sel, 1'h0}, a[3]);
      put_byte(ptr, a[2]);
      put_byte(d[15:8], a[1]);
      put_byte(d[7:0], a[0]);
      bus_stop;
      ok = &a;
   endtask
   task rd_reg(input logic [2:0] sel, input logic [7:0] ptr, output logic [15:0] d, output logic ok);
      logic [1:0] a;
      bus_start;
      put_byte({4'h3, sel, 1'h0}, a[1]);
      put_byte(ptr, a[0]);
      bus_start;
      put_byte({4'h3, sel, 1'h1}, ok);
      get_byte(1'h0, d[15:8]);
      get_byte(1'h1, d[7:0]);
      bus_stop;
      ok = ok & (&a);
   endtask
endmodule

// ==== bench/module_thermal_sensor_slave_tb_top.sv ====
// Purpose: self-checking bench for the thermal sensor slave
// Assumes: host model drives the bus, bench drives converter and straps
// Notes: bus bit period shortened to 32 clocks to keep the run short
`timescale 1ns/1ps
`include "mts_map.vh"
module module_thermal_sensor_slave_tb_top;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic [2:0] strap = 3'h0;
   logic [12:0] temp_sample = 13'h0;
   logic temp_valid = 1'h0;
   wire scl_line, sda_low, sda_out, sda_oe, alert_out, alert_oe;
   wire sda_line = !(sda_low || sda_oe);
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [15:0] rd;
   logic ok;
   always #5 clk = !clk;
   mts_host_model #(.Q(8)) host_u (.clk(clk), .sda_line(sda_line), .scl_line(scl_line), .sda_low(sda_low));
   mts_sensor dut_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
      .temp_sample(temp_sample), .temp_valid(temp_valid), .alert_out(alert_out), .alert_oe(alert_oe));
   task summarize;
      $display("Checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Ceiling above the roughly 80k cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         err_total = err_total + 1;
         summarize;
      end
   end
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task rchk(input logic [7:0] ptr, input logic [15:0] exp);
      host_u.rd_reg(strap, ptr, rd, ok);
      chk("read ack", {15'h0, ok}, 16'h1);
      chk("register", rd, exp);
   endtask
   task wr(input logic [7:0] ptr, input logic [15:0] d);
      host_u.wr_reg(strap, ptr, d, ok);
      chk("write ack", {15'h0, ok}, 16'h1);
   endtask
   task temp(input logic [12:0] t);
      temp_sample = t;
      temp_valid = 1'h1;
      @(posedge clk);
      #1 temp_valid = 1'h0;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task pin(input logic level);
      chk("alert pin", {15'h0, !alert_oe}, {15'h0, level});
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'h0;
      repeat (6) @(posedge clk);
      #1;
      for (int i = 0; i < 5; i++)
         rchk(8'(i), (i == 0) ? 16'h0001 : 16'h0000);
      $display("Test reset values done");
      for (int s = 0; s < 8; s++)
      begin
         strap = 3'(s);
         repeat (6) @(posedge clk);
         #1 rchk(8'h00, 16'h0001);
         host_u.wr_reg(strap ^ 3'h7, 8'h02, 16'h0FFC, ok);
         chk("stray ack", {15'h0, ok}, 16'h0);
      end
      rchk(8'h02, 16'h0000);
      $display("Test addressing done");
      wr(8'h00, 16'hFFFF);
      rchk(8'h00, 16'h0001);
      wr(8'h02, 16'hFFFF);
      rchk(8'h02, `MTS_LIMIT_MASK);
      wr(8'h06, 16'h1234);
      rchk(8'h06, 16'h0000);
      wr(8'h12, 16'h0400);
      rchk(8'h12, 16'h0000);
      rchk(8'h02, `MTS_LIMIT_MASK);
      $display("Test pointer done");
      wr(8'h02, 16'h0500);
      wr(8'h03, 16'h0100);
      wr(8'h04, 16'h0600);
      wr(8'h01, 16'h0008);
      temp(13'h0200);
      pin(1'h1);
      rchk(8'h05, 16'h0200);
      temp(13'h0540);
      pin(1'h0);
      wr(8'h01, 16'h0028);
      pin(1'h0);
      temp(13'h0200);
      pin(1'h1);
      temp(13'h1E74);
      pin(1'h0);
      rchk(8'h05, 16'h3E74);
      temp(13'h0200);
      $display("Test comparator done");
      wr(8'h01, 16'h0009);
      temp(13'h0540);
      temp(13'h0200);
      pin(1'h0);
      wr(8'h01, 16'h0009);
      pin(1'h0);
      wr(8'h01, 16'h0029);
      pin(1'h1);
      temp(13'h0640);
      wr(8'h01, 16'h0029);
      pin(1'h0);
      temp(13'h0200);
      wr(8'h01, 16'h0029);
      pin(1'h1);
      $display("Test interrupt done");
      wr(8'h01, 16'h000C);
      temp(13'h0540);
      pin(1'h1);
      temp(13'h0640);
      pin(1'h0);
      wr(8'h01, 16'h0000);
      pin(1'h1);
      wr(8'h01, 16'h0608);
      temp(13'h0540);
      temp(13'h04D0);
      pin(1'h0);
      temp(13'h0490);
      pin(1'h1);
      $display("Test critical and hysteresis done");
      // Inverted polarity: a quiet event now pulls the pin
      wr(8'h01, 16'h010A);
      pin(1'h0);
      // Shutdown: new samples must not reach the reading
      temp(13'h0540);
      rchk(8'h05, 16'h0490);
      pin(1'h0);
      $display("Test polarity and shutdown done");
      wr(8'h01, 16'h0040);
      wr(8'h01, 16'h0041);
      rchk(8'h01, 16'h0040);
      wr(8'h02, 16'h0200);
      rchk(8'h02, 16'h0500);
      wr(8'h01, 16'h0080);
      wr(8'h01, 16'h0081);
      rchk(8'h01, 16'h0080);
      wr(8'h04, 16'h0200);
      rchk(8'h04, 16'h0600);
      $display("Test lock done");
      summarize;
   end
endmodule
